/* smc_core_model.sv */
`include "smc_regs.svh"

// register-file side of the core: holds the high/low accumulator pair,
// feeds it to the unit and takes the long results back
module smc_core_model
    import smc_pkg::*;
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_load,
    input  wire logic [`SMC_LONG_W-1:0] i_load_val,
    input  wire logic                   i_res_valid,
    input  wire logic                   i_res_long,
    input  wire logic [`SMC_WORD_W-1:0] i_res_lo,
    input  wire logic [`SMC_WORD_W-1:0] i_res_hi,
    output logic      [`SMC_WORD_W-1:0] o_acc_lo,
    output logic      [`SMC_WORD_W-1:0] o_acc_hi
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [`SMC_LONG_W-1:0] acc_ff;
    logic [`SMC_LONG_W-1:0] nxt_acc;

    ////////////////////////////////////////////////////////////////////////
    // two distinct registers for high and low, never sp or pc
    always_comb begin
        nxt_acc = acc_ff;
        if (i_load) begin
            nxt_acc = i_load_val;
        end else if (i_res_valid && i_res_long) begin
            nxt_acc = {i_res_hi, i_res_lo};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    assign o_acc_lo = acc_ff[31:0];
    assign o_acc_hi = acc_ff[63:32];
endmodule

/* smc_halfword_mul.sv */
`include "smc_regs.svh"

// two signed 16x16 products; in single mode only the named halfwords
// reach the multiplier and the bottom product is forced to zero
module smc_halfword_mul
    import smc_pkg::*;
(
    input  wire logic [`SMC_WORD_W-1:0]  i_first_operand,
    input  wire logic [`SMC_WORD_W-1:0]  i_second_operand,
    input  wire logic                    i_crossed,
    input  wire logic                    i_single,
    input  wire logic                    i_first_top,
    input  wire logic                    i_second_top,
    output logic signed [`SMC_PROD_W-1:0] o_prod_top,
    output logic signed [`SMC_PROD_W-1:0] o_prod_bot
);

    logic signed [`SMC_HALF_W-1:0] a_top;
    logic signed [`SMC_HALF_W-1:0] a_bot;
    logic signed [`SMC_HALF_W-1:0] b_top;
    logic signed [`SMC_HALF_W-1:0] b_bot;
    logic signed [`SMC_HALF_W-1:0] h_first;
    logic signed [`SMC_HALF_W-1:0] h_second;

    assign a_top = i_first_operand[`SMC_TOP_MSB:`SMC_TOP_LSB];                    // RULE_02
    assign a_bot = i_first_operand[`SMC_BOT_MSB:`SMC_BOT_LSB];
    // crossed forms swap the halves of the second operand
    assign b_top = i_crossed ? i_second_operand[`SMC_BOT_MSB:`SMC_BOT_LSB]         // RULE_03
                             : i_second_operand[`SMC_TOP_MSB:`SMC_TOP_LSB];
    assign b_bot = i_crossed ? i_second_operand[`SMC_TOP_MSB:`SMC_TOP_LSB]
                             : i_second_operand[`SMC_BOT_MSB:`SMC_BOT_LSB];

    assign h_first  = i_first_top  ? a_top : a_bot;                                // RULE_06
    assign h_second = i_second_top ? i_second_operand[`SMC_TOP_MSB:`SMC_TOP_LSB]
                                   : i_second_operand[`SMC_BOT_MSB:`SMC_BOT_LSB];

    always_comb begin
        if (i_single) begin
            o_prod_top = h_first * h_second;                                       // RULE_07
            o_prod_bot = '0;
        end else begin
            o_prod_top = a_top * b_top;                                            // RULE_01
            o_prod_bot = a_bot * b_bot;
        end
    end

endmodule

/* smc_mac_unit.sv */
//Contract
//(RULE_01) plain dual word form: top*top plus bottom*bottom plus addend
//(RULE_02) operands are four signed 16-bit halfwords
//(RULE_03) crossed: first top times second bottom, vice versa
//(RULE_04) dual word forms set sticky flag on overflow
//(RULE_05) halfword long: sign-extended product added to 64-bit pair
//(RULE_06) bottom is [15:0], top [31:16], letters per operand
//(RULE_07) unnamed halfwords never affect the result
//(RULE_08) dual long: both products added to 64-bit pair
//(RULE_09) low word is bits 31:0, high word 63:32
//(RULE_10) long forms leave every flag unchanged
//(RULE_11) core never names same register high and low
//(RULE_12) core never uses stack pointer or program counter
//(RULE_13) dual subtract word: bottom minus top plus addend
//(RULE_14) dual subtract long: difference added to 64-bit pair
//(RULE_15) subtract word flags only accumulate overflow
//(RULE_16) condition predicate gates whether operation takes effect
//(RULE_17) sticky flag is the status word saturation bit
//(RULE_18) flag never cleared by these operations
//(RULE_19) 64-bit sums wrap silently modulo two to 64
`include "smc_regs.svh"

module smc_mac_unit
    import smc_pkg::*;
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_op_valid,
    input  wire smc_op_t                i_op_code,
    input  wire logic                   i_cond_pass,
    input  wire logic [`SMC_WORD_W-1:0] i_first_operand,
    input  wire logic [`SMC_WORD_W-1:0] i_second_operand,
    input  wire logic [`SMC_WORD_W-1:0] i_addend_input,
    input  wire logic [`SMC_WORD_W-1:0] i_result_low_word,
    input  wire logic [`SMC_WORD_W-1:0] i_result_high_word,
    input  wire logic                   i_sat_clear,
    output wire logic                   o_res_valid,
    output wire logic                   o_res_long,
    output wire logic                   o_op_illegal,
    output wire logic [`SMC_WORD_W-1:0] o_result_low_word,
    output wire logic [`SMC_WORD_W-1:0] o_result_high_word,
    output wire logic                   o_app_status_word_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // operation decode

    logic crossed;
    logic single;
    logic first_top;
    logic second_top;
    logic is_long;
    logic is_sub;
    logic legal;

    always_comb begin
        crossed    = 1'b0;
        single     = 1'b0;
        first_top  = 1'b0;
        second_top = 1'b0;
        is_long    = 1'b0;
        is_sub     = 1'b0;
        legal      = 1'b1;
        unique case (i_op_code)
            SMC_OP_DUAL_MAC_WORD: begin
            end
            SMC_OP_DUAL_MAC_WORD_CROSSED: begin
                crossed = 1'b1;
            end
            SMC_OP_DUAL_MSUB_WORD: begin
                is_sub = 1'b1;
            end
            SMC_OP_DUAL_MSUB_WORD_CROSSED: begin
                is_sub  = 1'b1;
                crossed = 1'b1;
            end
            SMC_OP_DUAL_MAC_LONG: begin
                is_long = 1'b1;
            end
            SMC_OP_DUAL_MAC_LONG_CROSSED: begin
                is_long = 1'b1;
                crossed = 1'b1;
            end
            SMC_OP_DUAL_MSUB_LONG: begin
                is_long = 1'b1;
                is_sub  = 1'b1;
            end
            SMC_OP_DUAL_MSUB_LONG_CROSSED: begin
                is_long = 1'b1;
                is_sub  = 1'b1;
                crossed = 1'b1;
            end
            SMC_OP_HALFWORD_MAC_LONG_BOT_BOT: begin
                is_long = 1'b1;
                single  = 1'b1;
            end
            SMC_OP_HALFWORD_MAC_LONG_BOT_TOP: begin
                is_long    = 1'b1;
                single     = 1'b1;
                second_top = 1'b1;
            end
            SMC_OP_HALFWORD_MAC_LONG_TOP_BOT: begin
                is_long   = 1'b1;
                single    = 1'b1;
                first_top = 1'b1;
            end
            SMC_OP_HALFWORD_MAC_LONG_TOP_TOP: begin
                is_long    = 1'b1;
                single     = 1'b1;
                first_top  = 1'b1;
                second_top = 1'b1;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // products and sums

    logic signed [`SMC_PROD_W-1:0] prod_top;
    logic signed [`SMC_PROD_W-1:0] prod_bot;

    smc_halfword_mul u_mul (
        .i_first_operand   (i_first_operand),
        .i_second_operand  (i_second_operand),
        .i_crossed         (crossed),
        .i_single          (single),
        .i_first_top       (first_top),
        .i_second_top      (second_top),
        .o_prod_top        (prod_top),
        .o_prod_bot        (prod_bot)
    );

    logic [`SMC_SUM_W-1:0]  pair_sum;
    logic [`SMC_SUM_W-1:0]  word_sum;
    logic                   word_ovf;
    logic [`SMC_LONG_W-1:0] acc_in;
    logic [`SMC_LONG_W-1:0] long_sum;
    logic                   take;

    // 34 bits hold two worst-case products plus the addend without loss
    assign pair_sum = is_sub
        ? {{2{prod_bot[31]}}, prod_bot} - {{2{prod_top[31]}}, prod_top}            // RULE_13
        : {{2{prod_bot[31]}}, prod_bot} + {{2{prod_top[31]}}, prod_top};
    assign word_sum = pair_sum + {{2{i_addend_input[31]}}, i_addend_input};
    // the pair sum can also leave the signed word range; only the final accumulate is checked
    assign word_ovf = (word_sum[33:31] != 3'h0) && (word_sum[33:31] != 3'h7);     // RULE_15
    assign acc_in   = {i_result_high_word, i_result_low_word};                    // RULE_09
    assign long_sum = acc_in + {{30{pair_sum[33]}}, pair_sum};                    // RULE_19
    assign take     = i_op_valid && i_cond_pass && legal;                         // RULE_16

    ////////////////////////////////////////////////////////////////////////////////
    // state

    smc_state_t st_ff;
    smc_state_t nxt_st;

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.res_valid  = 1'b0;
        nxt_st.op_illegal = i_op_valid && i_cond_pass && !legal;
        if (i_sat_clear) begin
            nxt_st.sat_q = 1'b0;
        end
        if (take) begin
            nxt_st.res_valid = 1'b1;
            nxt_st.res_long  = is_long;
            if (is_long) begin
                nxt_st.res_lo = long_sum[31:0];                                   // RULE_08
                nxt_st.res_hi = long_sum[63:32];                                  // RULE_14
            end else begin
                nxt_st.res_lo = word_sum[31:0];                                   // RULE_01
                nxt_st.res_hi = `SMC_RES_RST;
                // set wins over a same-cycle clear; no path clears it here
                if (word_ovf) begin
                    nxt_st.sat_q = 1'b1;                                          // RULE_04
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff.res_valid  <= 1'b0;
            st_ff.res_long   <= 1'b0;
            st_ff.op_illegal <= 1'b0;
            st_ff.sat_q      <= `SMC_SAT_RST;
            st_ff.res_lo     <= `SMC_RES_RST;
            st_ff.res_hi     <= `SMC_RES_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_res_valid         = st_ff.res_valid;
    assign o_res_long          = st_ff.res_long;
    assign o_op_illegal        = st_ff.op_illegal;
    assign o_result_low_word   = st_ff.res_lo;
    assign o_result_high_word  = st_ff.res_hi;
    assign o_app_status_word_q = st_ff.sat_q;                                     // RULE_17

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic signed [`SMC_PROD_W-1:0] ref_tt;
    logic signed [`SMC_PROD_W-1:0] ref_bb;
    logic signed [`SMC_PROD_W-1:0] ref_tb;
    logic signed [`SMC_PROD_W-1:0] ref_bt;
    logic [`SMC_LONG_W-1:0]        ref_tt64;
    logic [`SMC_LONG_W-1:0]        ref_bb64;
    logic [`SMC_LONG_W-1:0]        ref_tb64;
    logic [`SMC_LONG_W-1:0]        ref_bt64;
    logic                          go;

    assign ref_tt = $signed(i_first_operand[31:16]) * $signed(i_second_operand[31:16]);
    assign ref_bb = $signed(i_first_operand[15:0]) * $signed(i_second_operand[15:0]);
    assign ref_tb = $signed(i_first_operand[31:16]) * $signed(i_second_operand[15:0]);
    assign ref_bt = $signed(i_first_operand[15:0]) * $signed(i_second_operand[31:16]);
    assign ref_tt64 = {{32{ref_tt[31]}}, ref_tt};
    assign ref_bb64 = {{32{ref_bb[31]}}, ref_bb};
    assign ref_tb64 = {{32{ref_tb[31]}}, ref_tb};
    assign ref_bt64 = {{32{ref_bt[31]}}, ref_bt};
    assign go       = i_op_valid && i_cond_pass;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    chk_mac_word_sum: assert property ( // RULE_01
        go && i_op_code == SMC_OP_DUAL_MAC_WORD |=> o_res_valid && !o_res_long
            && o_result_low_word == $past(32'(ref_tt + ref_bb + i_addend_input)))
        else $error("dual word accumulate result wrong");

    chk_crossed_word_sum: assert property ( // RULE_03
        go && i_op_code == SMC_OP_DUAL_MAC_WORD_CROSSED |=>
            o_result_low_word == $past(32'(ref_tb + ref_bt + i_addend_input)))
        else $error("crossed word accumulate result wrong");

    chk_sat_on_ovf: assert property ( // RULE_04
        go && !is_long && legal && word_ovf |=> o_app_status_word_q
            ##1 (o_app_status_word_q || $past(i_sat_clear)))
        else $error("overflow did not set sticky flag");

    chk_half_long_sum: assert property ( // RULE_05
        go && i_op_code == SMC_OP_HALFWORD_MAC_LONG_BOT_TOP |=> o_res_long
            && {o_result_high_word, o_result_low_word}
               == $past({i_result_high_word, i_result_low_word} + ref_bt64))
        else $error("halfword long accumulate result wrong");

    chk_dual_long_sum: assert property ( // RULE_08
        go && i_op_code == SMC_OP_DUAL_MAC_LONG |=>
            {o_result_high_word, o_result_low_word}
            == $past({i_result_high_word, i_result_low_word} + ref_tt64 + ref_bb64))
        else $error("dual long accumulate result wrong");

    chk_long_flag_keep: assert property ( // RULE_10
        go && is_long && !i_sat_clear |=> $stable(o_app_status_word_q))
        else $error("long form changed the sticky flag");

    chk_msub_word_sum: assert property ( // RULE_13
        go && i_op_code == SMC_OP_DUAL_MSUB_WORD |=>
            o_result_low_word == $past(32'(ref_bb - ref_tt + i_addend_input)))
        else $error("subtract word result wrong");

    chk_msub_long_sum: assert property ( // RULE_14
        go && i_op_code == SMC_OP_DUAL_MSUB_LONG |=>
            {o_result_high_word, o_result_low_word}
            == $past({i_result_high_word, i_result_low_word} + ref_bb64 - ref_tt64))
        else $error("subtract long result wrong");

    chk_cond_skip: assert property ( // RULE_16
        i_op_valid && !i_cond_pass |=> !o_res_valid && $stable(o_result_low_word)
            && $stable(o_result_high_word))
        else $error("failed predicate still took effect");

    chk_sat_sticky: assert property ( // RULE_18
        o_app_status_word_q && !i_sat_clear |=> o_app_status_word_q)
        else $error("sticky flag dropped without a clear");

    chk_crossed_msub_word: assert property ( // RULE_13
        go && i_op_code == SMC_OP_DUAL_MSUB_WORD_CROSSED |=>
            o_result_low_word == $past(32'(ref_bt - ref_tb + i_addend_input)))
        else $error("crossed subtract word result wrong");

    chk_crossed_long_sum: assert property ( // RULE_03
        go && i_op_code == SMC_OP_DUAL_MAC_LONG_CROSSED |=>
            {o_result_high_word, o_result_low_word}
            == $past({i_result_high_word, i_result_low_word} + ref_tb64 + ref_bt64))
        else $error("crossed long accumulate result wrong");

    chk_half_top_top: assert property ( // RULE_06
        go && i_op_code == SMC_OP_HALFWORD_MAC_LONG_TOP_TOP |=>
            {o_result_high_word, o_result_low_word}
            == $past({i_result_high_word, i_result_low_word} + ref_tt64))
        else $error("top by top halfword long result wrong");

    chk_illegal_quiet: assert property ( // RULE_16
        go && !legal |=> o_op_illegal && !o_res_valid)
        else $error("unused code took effect");

    cov_word_ovf: cover property (go && !is_long && legal && word_ovf);
    cov_crossed_long: cover property (go && i_op_code == SMC_OP_DUAL_MSUB_LONG_CROSSED);
    cov_set_vs_clear: cover property (take && !is_long && word_ovf && i_sat_clear);
    cov_cond_skip: cover property (i_op_valid && !i_cond_pass);

endmodule

/* smc_mac_unit_tb.sv */
`include "smc_regs.svh"

module smc_mac_unit_tb
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0]  op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [63:0] acc;
    } smc_row_t;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        v = 1'b0;
    smc_op_t     opc = SMC_OP_DUAL_MAC_WORD;
    logic        cp = 1'b0;
    logic        sat_clr = 1'b0;
    logic        ld = 1'b0;
    logic [63:0] ld_val = '0;
    logic [31:0] a_in = '0;
    logic [31:0] b_in = '0;
    logic [31:0] c_in = '0;
    logic [31:0] acc_lo;
    logic [31:0] acc_hi;
    logic        res_valid;
    logic        res_long;
    logic        op_illegal;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    logic        sat_q;
    logic        exp_sat = 1'b0;
    logic [63:0] r;
    logic [63:0] held;
    logic        ovf;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    smc_row_t rows [13] = '{
        '{4'h0, 32'h80008000, 32'h80008000, 32'h80000000, 64'h0},
        '{4'h0, 32'h7FFF7FFF, 32'h7FFF7FFF, 32'h7FFFFFFF, 64'h0},
        '{4'h1, 32'h12345678, 32'h9ABCDEF0, 32'h00001000, 64'h5},
        '{4'h2, 32'h80008000, 32'h7FFF8000, 32'h00000010, 64'h0},
        '{4'h3, 32'hFFFF0001, 32'h0002FFFE, 32'h80000000, 64'h0},
        '{4'h4, 32'h7FFF8000, 32'h80007FFF, 32'h0, 64'hFFFFFFFF_FFFFFFFF},
        '{4'h5, 32'h12345678, 32'h9ABCDEF0, 32'h0, 64'h00000001_FFFFFFFF},
        '{4'h6, 32'h80008000, 32'h7FFF7FFF, 32'h0, 64'h80000000_00000000},
        '{4'h7, 32'h0003FFFD, 32'h00050007, 32'h0, 64'h7FFFFFFF_FFFFFFFF},
        '{4'h8, 32'hAAAA8000, 32'h55558000, 32'h0, 64'h00000000_00000005},
        '{4'h9, 32'hBBBB8000, 32'h7FFF1234, 32'h0, 64'hFFFFFFFF_00000000},
        '{4'hA, 32'h8000CCCC, 32'h7FFFDDDD, 32'h0, 64'h00000000_00000001},
        '{4'hB, 32'h80001111, 32'h80002222, 32'h0, 64'h7FFFFFFF_FFFFFFFF}
    };

    smc_mac_unit u_dut (
        .i_core_clk         (clk),
        .i_rstn             (rstn),
        .i_op_valid         (v),
        .i_op_code          (opc),
        .i_cond_pass        (cp),
        .i_first_operand    (a_in),
        .i_second_operand   (b_in),
        .i_addend_input     (c_in),
        .i_result_low_word  (acc_lo),
        .i_result_high_word (acc_hi),
        .i_sat_clear        (sat_clr),
        .o_res_valid        (res_valid),
        .o_res_long         (res_long),
        .o_op_illegal       (op_illegal),
        .o_result_low_word  (res_lo),
        .o_result_high_word (res_hi),
        .o_app_status_word_q(sat_q)
    );

    smc_core_model u_core (
        .i_core_clk (clk),
        .i_rstn     (rstn),
        .i_load     (ld),
        .i_load_val (ld_val),
        .i_res_valid(res_valid),
        .i_res_long (res_long),
        .i_res_lo   (res_lo),
        .i_res_hi   (res_hi),
        .o_acc_lo   (acc_lo),
        .o_acc_hi   (acc_hi)
    );

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // reference arithmetic on four signed halfwords
    function automatic void calc(input logic [3:0] op, input logic [31:0] a, b, c,
                                 input logic [63:0] acc, output logic [63:0] res,
                                 output logic of);
        longint at, ab, bt, bb, pt, pb, s;
        at = longint'($signed(a[31:16]));
        ab = longint'($signed(a[15:0]));
        bt = longint'($signed(b[31:16]));
        bb = longint'($signed(b[15:0]));
        pt = at * (op[0] ? bb : bt);
        pb = ab * (op[0] ? bt : bb);
        if (op >= 4'h8) begin
            pt = 0;
            pb = (op[1] ? at : ab) * (op[0] ? bt : bb);
        end
        s = (op[1] && op < 4'h8) ? pb - pt : pb + pt;
        of = 1'b0;
        if (op < 4'h4) begin
            s = s + longint'($signed(c));
            res = {32'h0, s[31:0]};
            of = (s[63:31] != {33{s[31]}});
        end else begin
            res = acc + s;
        end
    endfunction

    task automatic do_op(input logic [3:0] op, input logic [31:0] a, b, c,
                         input logic cnd, input logic [63:0] acc);
        @(posedge clk);
        ld <= 1'b1;
        ld_val <= acc;
        @(posedge clk);
        ld <= 1'b0;
        v <= 1'b1;
        cp <= cnd;
        opc <= smc_op_t'(op);
        a_in <= a;
        b_in <= b;
        c_in <= c;
        @(posedge clk);
        v <= 1'b0;
        @(negedge clk);
    endtask

    task automatic chk_row(input smc_row_t rw);
        calc(rw.op, rw.a, rw.b, rw.c, rw.acc, r, ovf);
        if (ovf) begin
            exp_sat = 1'b1;
        end
        chk(res_valid, 1'b1);
        chk({res_hi, res_lo}, r);
        chk(res_long, rw.op >= 4'h4);
        chk(sat_q, exp_sat);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].a, rows[i].b, rows[i].c, 1'b1, rows[i].acc);
            chk_row(rows[i]);
        end
        // failed predicate: nothing happens
        held = {res_hi, res_lo};
        do_op(4'h0, 32'h7FFF7FFF, 32'h7FFF7FFF, 32'h7FFFFFFF, 1'b0, 64'h0);
        chk(res_valid, 1'b0);
        chk({res_hi, res_lo}, held);
        // unused codes only pulse the illegal flag
        for (int k = 12; k < 16; k++) begin
            @(posedge clk);
            v <= 1'b1;
            cp <= 1'b1;
            opc <= smc_op_t'(k[3:0]);
            @(posedge clk);
            v <= 1'b0;
            @(negedge clk);
            chk(op_illegal, 1'b1);
            chk(res_valid, 1'b0);
            chk({res_hi, res_lo}, held);
        end
        // clear, then subtract form overflowing only in the accumulate
        @(posedge clk);
        sat_clr <= 1'b1;
        @(posedge clk);
        sat_clr <= 1'b0;
        @(negedge clk);
        chk(sat_q, 1'b0);
        exp_sat = 1'b0;
        rows[0] = '{4'h2, 32'h00008000, 32'h00007FFF, 32'h80000000, 64'h0};
        do_op(rows[0].op, rows[0].a, rows[0].b, rows[0].c, 1'b1, 64'h0);
        chk_row(rows[0]);
        // back to back word ops; flag must survive a clean one
        rows[1] = '{4'h1, 32'h00010002, 32'h00030004, 32'h00000007, 64'h0};
        rows[2] = '{4'h3, 32'hFFFE0005, 32'h0009FFF7, 32'h00000100, 64'h0};
        @(posedge clk);
        v <= 1'b1;
        opc <= smc_op_t'(rows[1].op);
        a_in <= rows[1].a;
        b_in <= rows[1].b;
        c_in <= rows[1].c;
        @(posedge clk);
        opc <= smc_op_t'(rows[2].op);
        a_in <= rows[2].a;
        b_in <= rows[2].b;
        c_in <= rows[2].c;
        @(negedge clk);
        chk_row(rows[1]);
        @(posedge clk);
        v <= 1'b0;
        @(negedge clk);
        chk_row(rows[2]);
        @(negedge clk);
        chk(res_valid, 1'b0);
        // reset in mid-run clears every output
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({res_hi, res_lo}, '0);
        chk({res_valid, res_long, op_illegal, sat_q}, '0);
        @(posedge clk);
        rstn <= 1'b1;
        // first op after release: overflow and clear in one cycle, set wins
        sat_clr <= 1'b1;
        exp_sat = 1'b0;
        rows[3] = '{4'h0, 32'h7FFF7FFF, 32'h7FFF7FFF, 32'h7FFFFFFF, 64'h0};
        do_op(rows[3].op, rows[3].a, rows[3].b, rows[3].c, 1'b1, 64'h0);
        chk_row(rows[3]);
        @(posedge clk);
        sat_clr <= 1'b0;
        @(negedge clk);
        chk(sat_q, 1'b0);
        end_sim();
    end
endmodule

/* smc_pkg.sv */
`include "smc_regs.svh"

package smc_pkg;

    typedef enum logic [3:0] {
        SMC_OP_DUAL_MAC_WORD           = 4'h0,
        SMC_OP_DUAL_MAC_WORD_CROSSED   = 4'h1,
        SMC_OP_DUAL_MSUB_WORD          = 4'h2,
        SMC_OP_DUAL_MSUB_WORD_CROSSED  = 4'h3,
        SMC_OP_DUAL_MAC_LONG           = 4'h4,
        SMC_OP_DUAL_MAC_LONG_CROSSED   = 4'h5,
        SMC_OP_DUAL_MSUB_LONG          = 4'h6,
        SMC_OP_DUAL_MSUB_LONG_CROSSED  = 4'h7,
        SMC_OP_HALFWORD_MAC_LONG_BOT_BOT = 4'h8,
        SMC_OP_HALFWORD_MAC_LONG_BOT_TOP = 4'h9,
        SMC_OP_HALFWORD_MAC_LONG_TOP_BOT = 4'hA,
        SMC_OP_HALFWORD_MAC_LONG_TOP_TOP = 4'hB
    } smc_op_t;

    typedef struct packed {
        logic                   res_valid;
        logic                   res_long;
        logic                   op_illegal;
        logic                   sat_q;
        logic [`SMC_WORD_W-1:0] res_lo;
        logic [`SMC_WORD_W-1:0] res_hi;
    } smc_state_t;

endpackage

/* smc_regs.svh */
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// operand and accumulator widths
`define SMC_HALF_W      16
`define SMC_WORD_W      32
`define SMC_PROD_W      32
`define SMC_SUM_W       34
`define SMC_LONG_W      64

// halfword field positions inside a word
`define SMC_BOT_LSB     0
`define SMC_BOT_MSB     15
`define SMC_TOP_LSB     16
`define SMC_TOP_MSB     31

// reset values
`define SMC_RES_RST     32'h0000_0000
`define SMC_SAT_RST     1'b0

`endif
